// ---- dlic_defines.vh ----
// Constants for the dual level interrupt controller.
// Assumes inclusion by bare name from the design files.
`ifndef DLIC_DEFINES_VH
`define DLIC_DEFINES_VH

// ==========================================================
// Register byte offsets
`define DLIC_OFS_NORMAL_RAW      8'h00
`define DLIC_OFS_NORMAL_ENABLE   8'h04
`define DLIC_OFS_NORMAL_CLEAR    8'h08
`define DLIC_OFS_NORMAL_STATUS   8'h0c
`define DLIC_OFS_FAST_RAW        8'h10
`define DLIC_OFS_FAST_ENABLE     8'h14
`define DLIC_OFS_FAST_CLEAR      8'h18
`define DLIC_OFS_FAST_STATUS     8'h1c
`define DLIC_OFS_SWI_CONFIG      8'h20

// ==========================================================
// Register indices returned by the decoder
`define DLIC_IDX_NORMAL_RAW      4'h0
`define DLIC_IDX_NORMAL_ENABLE   4'h1
`define DLIC_IDX_NORMAL_CLEAR    4'h2
`define DLIC_IDX_NORMAL_STATUS   4'h3
`define DLIC_IDX_FAST_RAW        4'h4
`define DLIC_IDX_FAST_ENABLE     4'h5
`define DLIC_IDX_FAST_CLEAR      4'h6
`define DLIC_IDX_FAST_STATUS     4'h7
`define DLIC_IDX_SWI_CONFIG      4'h8
`define DLIC_IDX_NONE            4'hf

// ==========================================================
// Source vector bit positions
`define DLIC_BIT_FAST_OR         0
`define DLIC_BIT_PROGRAMMED      1
`define DLIC_BIT_TIMER0          2
`define DLIC_BIT_TIMER1          3
`define DLIC_BIT_TIMER2          4
`define DLIC_BIT_LIN             5
`define DLIC_BIT_MEMORY          6
`define DLIC_BIT_PLL_LOCK        7
`define DLIC_BIT_ADC             8
`define DLIC_BIT_SPI             9
`define DLIC_BIT_HIGH_VOLTAGE    10
`define DLIC_BIT_OSC_CAL         11
`define DLIC_BIT_EXT_PIN         13

// Programmed interrupt config bits
`define DLIC_SWI_NORMAL_BIT      1
`define DLIC_SWI_FAST_BIT        2

// ==========================================================
// Masks and reset values
`define DLIC_ENABLE_MASK         32'h0000_2ffc
`define DLIC_SWI_MASK            32'h0000_0006
`define DLIC_ENABLE_RESET        32'h0000_0000
`define DLIC_SWI_RESET           32'h0000_0000

// AXI response codes
`define DLIC_RESP_OKAY           2'b00
`define DLIC_RESP_SLVERR         2'b10

`endif

// ---- dlic_periph_model.sv ----
// Peripheral request sources facing the controller.
// Assumes the bench sets levels and timer0 set or clear pulses on aclk.
`timescale 1ns/1ps
`default_nettype none
module dlic_periph_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [13:0] lvl,
    input  wire logic        t0_set,
    input  wire logic        t0_clr,
    output logic             timer0_req,
    output logic             timer1_req,
    output logic             timer2_req,
    output logic             lin_req,
    output logic             memory_req,
    output logic             pll_lock_req,
    output logic             adc_req,
    output logic             spi_req,
    output logic             high_voltage_req,
    output logic             osc_cal_req,
    output logic             external_pin_request
);
// ==========================================================
// Timer0 flag stays set until its own clear, enables play no part
always_ff @(posedge aclk) begin
    if (!aresetn || t0_clr) begin
        timer0_req <= 1'b0;
    end else if (t0_set) begin
        timer0_req <= 1'b1;
    end
end
// Levels change only when the bench says, well apart in time
assign {external_pin_request, osc_cal_req, high_voltage_req, spi_req, adc_req, pll_lock_req,
        memory_req, lin_req, timer2_req, timer1_req} = {lvl[13], lvl[11:3]};
endmodule
`default_nettype wire

// ---- dlic_pin_sync.v ----
// Three stage synchroniser for a level arriving from a pin.
// Assumes the pin is asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module dlic_pin_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire pin_async,
    output reg  pin_level
);

    reg stage1;
    reg stage2;
    reg stage3;

    // ==========================================================
    // Sync chain
    // Only stage2 reads stage1; metastability stays in stage1
    always @(posedge aclk) begin
        if (!aresetn) begin
            stage1    <= 1'b0;
            stage2    <= 1'b0;
            stage3    <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            stage1 <= pin_async;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                pin_level <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// ---- dlic_top.v ----
// Dual level interrupt controller with AXI4-Lite register access.
// Assumes on-chip request lines on aclk; the external pin is async.
`timescale 1ns/1ps
`default_nettype none
`include "dlic_defines.vh"

module dlic_top #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]        s_axi_awprot,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]        s_axi_arprot,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Peripheral request lines
    input  wire              timer0_req,
    input  wire              timer1_req,
    input  wire              timer2_req,
    input  wire              lin_req,
    input  wire              memory_req,
    input  wire              pll_lock_req,
    input  wire              adc_req,
    input  wire              spi_req,
    input  wire              high_voltage_req,
    input  wire              osc_cal_req,
    input  wire              external_pin_request,
    // Core exception inputs
    output reg               normal_request,
    output reg               fast_request
);

    // ==========================================================
    // Address decode
    // Used by both the write and the read path
    function [3:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            case (addr)
                `DLIC_OFS_NORMAL_RAW:    reg_index = `DLIC_IDX_NORMAL_RAW;
                `DLIC_OFS_NORMAL_ENABLE: reg_index = `DLIC_IDX_NORMAL_ENABLE;
                `DLIC_OFS_NORMAL_CLEAR:  reg_index = `DLIC_IDX_NORMAL_CLEAR;
                `DLIC_OFS_NORMAL_STATUS: reg_index = `DLIC_IDX_NORMAL_STATUS;
                `DLIC_OFS_FAST_RAW:      reg_index = `DLIC_IDX_FAST_RAW;
                `DLIC_OFS_FAST_ENABLE:   reg_index = `DLIC_IDX_FAST_ENABLE;
                `DLIC_OFS_FAST_CLEAR:    reg_index = `DLIC_IDX_FAST_CLEAR;
                `DLIC_OFS_FAST_STATUS:   reg_index = `DLIC_IDX_FAST_STATUS;
                `DLIC_OFS_SWI_CONFIG:    reg_index = `DLIC_IDX_SWI_CONFIG;
                default:                 reg_index = `DLIC_IDX_NONE;
            endcase
        end
    endfunction

    // Byte strobes widened to a bit mask
    function [31:0] strobe_mask;
        input [3:0] strb;
        begin
            strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    // ==========================================================
    // Declarations
    reg  [ADDR_W-1:0] wr_addr;
    reg  [31:0]       wr_data;
    reg  [3:0]        wr_strb;
    reg               aw_held;
    reg               w_held;
    reg  [31:0]       normal_enable_mask;
    reg  [31:0]       fast_enable_mask;
    reg  [31:0]       software_interrupt_config;

    wire              ext_pin_level;
    wire              wr_fire;
    wire [3:0]        wr_index;
    wire [3:0]        rd_index;
    wire [31:0]       wr_bits;

    wire [31:0]       source_vector;
    wire [31:0]       normal_raw_signal;
    wire [31:0]       fast_raw_signal;
    wire [31:0]       normal_masked_status;
    wire [31:0]       fast_masked_status;
    wire [31:1]       fast_status_upper;
    wire              fast_or;

    reg  [31:0]       read_value;

    // ==========================================================
    // External pin synchroniser
    dlic_pin_sync u_ext_pin_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_async (external_pin_request),
        .pin_level (ext_pin_level)
    );

    // ==========================================================
    // Source vector
    // Raw bits are a live view; a pulse shorter than a cycle is lost
    assign source_vector[`DLIC_BIT_FAST_OR]      = 1'b0;
    assign source_vector[`DLIC_BIT_PROGRAMMED]   = 1'b0;
    assign source_vector[`DLIC_BIT_TIMER0]       = timer0_req;
    assign source_vector[`DLIC_BIT_TIMER1]       = timer1_req;
    assign source_vector[`DLIC_BIT_TIMER2]       = timer2_req;
    assign source_vector[`DLIC_BIT_LIN]          = lin_req;
    assign source_vector[`DLIC_BIT_MEMORY]       = memory_req;
    assign source_vector[`DLIC_BIT_PLL_LOCK]     = pll_lock_req;
    assign source_vector[`DLIC_BIT_ADC]          = adc_req;
    assign source_vector[`DLIC_BIT_SPI]          = spi_req;
    assign source_vector[`DLIC_BIT_HIGH_VOLTAGE] = high_voltage_req;
    assign source_vector[`DLIC_BIT_OSC_CAL]      = osc_cal_req;
    assign source_vector[12]                     = 1'b0;
    assign source_vector[`DLIC_BIT_EXT_PIN]      = ext_pin_level;
    assign source_vector[31:14]                  = 18'h0_0000;

    // ==========================================================
    // Raw signal views
    // Read-only mirrors of the request lines
    assign normal_raw_signal = {source_vector[31:2],
                                software_interrupt_config[`DLIC_SWI_NORMAL_BIT],
                                fast_or};

    assign fast_raw_signal   = {source_vector[31:2],
                                software_interrupt_config[`DLIC_SWI_FAST_BIT],
                                fast_or};

    // ==========================================================
    // Masked status
    // Bit 1 bypasses the mask: programmed requests are unmaskable
    assign fast_status_upper = {fast_raw_signal[31:2] & fast_enable_mask[31:2],
                                fast_raw_signal[1]};
    assign fast_or           = |fast_status_upper;
    assign fast_masked_status   = {fast_status_upper, fast_or};
    assign normal_masked_status = {normal_raw_signal[31:2] & normal_enable_mask[31:2],
                                   normal_raw_signal[1],
                                   fast_or};

    // ==========================================================
    // Core request outputs
    // Independent of the core's own disable flags; no vector output
    always @(posedge aclk) begin
        if (!aresetn) begin
            normal_request <= 1'b0;
            fast_request   <= 1'b0;
        end else begin
            normal_request <= |normal_masked_status;
            fast_request   <= fast_or;
        end
    end

    // ==========================================================
    // AXI write channel
    assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
    assign wr_index = reg_index(wr_addr);
    assign wr_bits  = wr_data & strobe_mask(wr_strb);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DLIC_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= {ADDR_W{1'b0}};
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            if (!aw_held && !s_axi_bvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end

            if (!w_held && !s_axi_bvalid && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end

            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                wr_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end

            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end

            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_index == `DLIC_IDX_NONE) begin
                    s_axi_bresp <= `DLIC_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `DLIC_RESP_OKAY;
                end
            end

            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Enable masks and programmed interrupt config
    // Only implemented sources are writable; enable mask bits 0 and 1 stay zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            normal_enable_mask        <= `DLIC_ENABLE_RESET;
            fast_enable_mask          <= `DLIC_ENABLE_RESET;
            software_interrupt_config <= `DLIC_SWI_RESET;
        end else if (wr_fire) begin
            case (wr_index)
                `DLIC_IDX_NORMAL_ENABLE: begin
                    normal_enable_mask <= normal_enable_mask | (wr_bits & `DLIC_ENABLE_MASK);
                    fast_enable_mask   <= fast_enable_mask & ~(wr_bits & `DLIC_ENABLE_MASK);
                end

                `DLIC_IDX_NORMAL_CLEAR: begin
                    normal_enable_mask <= normal_enable_mask & ~wr_bits;
                end

                `DLIC_IDX_FAST_ENABLE: begin
                    fast_enable_mask   <= fast_enable_mask | (wr_bits & `DLIC_ENABLE_MASK);
                    normal_enable_mask <= normal_enable_mask & ~(wr_bits & `DLIC_ENABLE_MASK);
                end

                `DLIC_IDX_FAST_CLEAR: begin
                    fast_enable_mask <= fast_enable_mask & ~wr_bits;
                end

                `DLIC_IDX_SWI_CONFIG: begin
                    software_interrupt_config <= (software_interrupt_config & ~(strobe_mask(wr_strb)
                                                 & `DLIC_SWI_MASK)) | (wr_bits & `DLIC_SWI_MASK);
                end

                default: begin
                    normal_enable_mask <= normal_enable_mask;
                end
            endcase
        end
    end

    // ==========================================================
    // Read mux
    // Write-only clear registers read as zero
    assign rd_index = reg_index(s_axi_araddr);

    always @* begin
        case (rd_index)
            `DLIC_IDX_NORMAL_RAW:    read_value = normal_raw_signal;
            `DLIC_IDX_NORMAL_ENABLE: read_value = normal_enable_mask;
            `DLIC_IDX_NORMAL_STATUS: read_value = normal_masked_status;
            `DLIC_IDX_FAST_RAW:      read_value = fast_raw_signal;
            `DLIC_IDX_FAST_ENABLE:   read_value = fast_enable_mask;
            `DLIC_IDX_FAST_STATUS:   read_value = fast_masked_status;
            `DLIC_IDX_SWI_CONFIG:    read_value = software_interrupt_config;
            default:                 read_value = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // AXI read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DLIC_RESP_OKAY;
        end else begin
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end

            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= read_value;
                if (rd_index == `DLIC_IDX_NONE) begin
                    s_axi_rresp <= `DLIC_RESP_SLVERR;
                end else begin
                    s_axi_rresp <= `DLIC_RESP_OKAY;
                end
            end

            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ---- dlic_top_checker.sv ----
// Port checker for the dual level interrupt controller.
// Assumes binding to dlic_top; enables are mirrored from observed writes.
`timescale 1ns/1ps
`default_nettype none
`include "dlic_defines.vh"
module dlic_top_checker #(
    parameter ADDR_W = 8
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              timer0_req,
    input wire logic              timer1_req,
    input wire logic              timer2_req,
    input wire logic              lin_req,
    input wire logic              memory_req,
    input wire logic              pll_lock_req,
    input wire logic              adc_req,
    input wire logic              spi_req,
    input wire logic              high_voltage_req,
    input wire logic              osc_cal_req,
    input wire logic              external_pin_request,
    input wire logic              normal_request,
    input wire logic              fast_request
);
// ==========================================================
// Shadow state, one cycle behind the design like its outputs
logic [ADDR_W-1:0] wa;
logic [31:0]       wd, m, d, en_n, en_f, rd, fs;
logic [3:0]        ws;
logic [2:1]        programmed_interrupt;
logic              bv_d, ext_q, fo;
logic [2:0]        ext_cnt;
assign m  = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
assign d  = wd & m & `DLIC_ENABLE_MASK;
assign fs = (rd & en_f) | {29'h0, programmed_interrupt[2], 1'b0};
assign fo = |fs;
always_ff @(posedge aclk) begin
    rd <= {18'h0, external_pin_request, 1'b0, osc_cal_req, high_voltage_req, spi_req, adc_req,
           pll_lock_req, memory_req, lin_req, timer2_req, timer1_req, timer0_req, 2'b00};
    ext_q <= external_pin_request;
    if (s_axi_awvalid && s_axi_awready) begin
        wa <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
    end
    if (!aresetn) begin
        en_n    <= 32'h0;
        en_f    <= 32'h0;
        programmed_interrupt     <= 2'b00;
        bv_d    <= 1'b0;
        ext_cnt <= 3'd0;
    end else begin
        bv_d    <= s_axi_bvalid;
        // Pin goes through a synchroniser, so only trust it once settled
        ext_cnt <= (ext_q != external_pin_request) ? 3'd0 : ext_cnt + {2'b00, ext_cnt != 3'd7};
        if (s_axi_bvalid && !bv_d) begin
            case (wa)
                `DLIC_OFS_NORMAL_ENABLE: begin
                    en_n <= en_n | d;
                    en_f <= en_f & ~d;
                end
                `DLIC_OFS_FAST_ENABLE: begin
                    en_f <= en_f | d;
                    en_n <= en_n & ~d;
                end
                `DLIC_OFS_NORMAL_CLEAR: en_n <= en_n & ~d;
                `DLIC_OFS_FAST_CLEAR: en_f <= en_f & ~d;
                `DLIC_OFS_SWI_CONFIG: programmed_interrupt <= (programmed_interrupt & ~m[2:1]) | (wd[2:1] & m[2:1]);
                default: ;
            endcase
        end
    end
end
// ==========================================================
// Assertions
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
a_norm_req_or: assert property (ext_cnt == 3'd7 |-> normal_request == (|(rd & en_n) || programmed_interrupt[1] || fo))
    else $error("normal request differs from enabled sources");
a_fast_req_or: assert property (ext_cnt == 3'd7 |-> fast_request == fo)
    else $error("fast request differs from fast status");
a_fast_in_norm: assert property (fast_request |-> normal_request)
    else $error("fast source missing from normal request");
a_swi_normal: assert property (programmed_interrupt[1] |-> normal_request)
    else $error("programmed normal interrupt not raised");
a_swi_fast: assert property (programmed_interrupt[2] |-> fast_request)
    else $error("programmed fast interrupt not raised");
a_reset_quiet: assert property ($rose(aresetn) |-> !normal_request && !fast_request && !s_axi_bvalid)
    else $error("outputs active after reset");
a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_W'(8'h20)
    |=> s_axi_rvalid && s_axi_rresp == `DLIC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
c_swi_normal: cover property (programmed_interrupt[1] && normal_request);
c_fast_rise: cover property ($rose(fast_request));
c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `DLIC_RESP_SLVERR);
endmodule
bind dlic_top dlic_top_checker #(.ADDR_W(ADDR_W)) u_checker (.*);
`default_nettype wire

// ---- dlic_top_tb_top.sv ----
// Self-checking bench for the dual level interrupt controller.
// Assumes dlic_top, its checker and the peripheral model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dlic_defines.vh"
module dlic_top_tb_top;
logic        aclk, aresetn, t0_set, t0_clr, t0;
logic [7:0]  s_axi_awaddr, s_axi_araddr, tbl [8];
logic [2:0]  s_axi_awprot, s_axi_arprot;
logic [31:0] s_axi_wdata, s_axi_rdata, en_n, en_f, exp_rd[$];
logic [3:0]  s_axi_wstrb;
logic [1:0]  s_axi_bresp, s_axi_rresp, exp_rr[$], exp_b[$];
logic [2:1]  programmed_interrupt;
logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic        timer0_req, timer1_req, timer2_req, lin_req, memory_req, pll_lock_req, adc_req, spi_req;
logic        high_voltage_req, osc_cal_req, external_pin_request, normal_request, fast_request;
logic [13:0] lvl;
logic [4:0]  hsv;
int          failures, total_checks, seed;
assign hsv = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_wready, s_axi_awready};
dlic_top #(.ADDR_W(8)) DUT (.*);
dlic_periph_model PERIPH (.*);
always #4 aclk = ~aclk;
// ==========================================================
// Helpers
task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
endtask
task automatic await(input int k);
    int n;
    n = 0;
    do begin
        @(posedge aclk);
        n++;
    end while (hsv[k] !== 1'b1 && n < 64);
    if (hsv[k] !== 1'b1) begin
        failures++;
        report_and_stop();
    end
endtask
function automatic logic [1:0] rsp(input logic [7:0] a);
    rsp = (a > 8'h20 || a[1:0] != 2'b00) ? `DLIC_RESP_SLVERR : `DLIC_RESP_OKAY;
endfunction
function automatic logic [31:0] ex(input logic [7:0] a);
    logic [31:0] r, fs;
    logic        fo;
    r  = {18'h0, lvl[13], 1'b0, lvl[11:3], t0, 2'b00};
    fs = (r & en_f) | {29'h0, programmed_interrupt[2], 1'b0};
    fo = |fs;
    case (a)
        8'h00: ex = r | {30'h0, programmed_interrupt[1], fo};
        8'h04: ex = en_n;
        8'h0c: ex = (r & en_n) | {30'h0, programmed_interrupt[1], fo};
        8'h10: ex = r | {30'h0, programmed_interrupt[2], fo};
        8'h14: ex = en_f;
        8'h1c: ex = fs | {31'h0, fo};
        8'h20: ex = {29'h0, programmed_interrupt, 1'b0};
        default: ex = 32'h0;
    endcase
endfunction
// ==========================================================
// Bus master, shadow kept beside it
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m, dm;
    m  = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    dm = d & m & `DLIC_ENABLE_MASK;
    exp_b.push_back(rsp(a));
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    fork
        begin
            await(0);
            s_axi_awvalid <= 1'b0;
        end
        begin
            await(1);
            s_axi_wvalid <= 1'b0;
        end
    join
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    await(2);
    s_axi_bready <= 1'b0;
    case (a)
        8'h04: begin
            en_n = en_n | dm;
            en_f = en_f & ~dm;
        end
        8'h14: begin
            en_f = en_f | dm;
            en_n = en_n & ~dm;
        end
        8'h08: en_n = en_n & ~dm;
        8'h18: en_f = en_f & ~dm;
        8'h20: programmed_interrupt = (programmed_interrupt & ~m[2:1]) | (d[2:1] & m[2:1]);
        default: ;
    endcase
endtask
task automatic rd(input logic [7:0] a);
    exp_rd.push_back(ex(a));
    exp_rr.push_back(rsp(a));
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    await(3);
    s_axi_arvalid <= 1'b0;
    // Late ready exercises the slave holding its answer
    repeat ($random(seed) & 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    await(4);
    s_axi_rready <= 1'b0;
endtask
task automatic check_all;
    repeat (8) @(posedge aclk);
    cmp("normal request", |ex(8'h0c), normal_request);
    cmp("fast request", |(ex(8'h1c) >> 1), fast_request);
    for (int i = 0; i < 11; i++) begin
        rd(8'(i * 4));
    end
    rd(8'h02);
endtask
task automatic stim(input logic [13:0] l, input logic set);
    @(posedge aclk);
    lvl    <= l;
    t0_set <= set;
    t0_clr <= !set;
    t0 = set;
    @(posedge aclk);
    t0_set <= 1'b0;
    t0_clr <= 1'b0;
endtask
task automatic do_reset;
    aresetn <= 1'b0;
    en_n = 32'h0;
    en_f = 32'h0;
    programmed_interrupt = 2'b00;
    t0 = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
endtask
// ==========================================================
// Result monitor
always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_rd.size() > 0) begin
        cmp("read data", exp_rd.pop_front(), s_axi_rdata);
        cmp("read resp", exp_rr.pop_front(), s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0) begin
        cmp("write resp", exp_b.pop_front(), s_axi_bresp);
    end
end
// ==========================================================
// Main sequence
initial begin
    seed = 25344;
    tbl = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h20, 8'h00, 8'h1c, 8'h40};
    {aclk, aresetn, t0_set, t0_clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 24'h0;
    {s_axi_wdata, s_axi_wstrb, lvl} = 50'h0;
    do_reset();
    check_all();
    wr(8'h04, 32'hffff_ffff, 4'hf);
    wr(8'h04, 32'h0, 4'hf);
    stim(14'h3fff, 1'b1);
    check_all();
    wr(8'h14, 32'hffff_ffff, 4'hf);
    check_all();
    wr(8'h04, 32'h0000_0104, 4'hf);
    wr(8'h08, 32'hffff_ffff, 4'h2);
    wr(8'h20, 32'hffff_ffff, 4'hf);
    check_all();
    stim(14'h0000, 1'b0);
    check_all();
    for (int k = 0; k < 24; k++) begin
        stim(14'($random(seed)), ($random(seed) & 1) != 0);
        wr(tbl[$random(seed) & 7], $random(seed), 4'($random(seed)));
        check_all();
    end
    do_reset();
    check_all();
    report_and_stop();
end
endmodule
`default_nettype wire
